// ===== rtl/sbsc_defs.svh
// offsets, field positions, reset values and widths for the burst memory control
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH

`define SBSC_LANE_W       9
`define SBSC_PAR_POS      8
`define SBSC_MAX_LANES    4
`define SBSC_APB_AW       12
`define SBSC_APB_DW       32

`define SBSC_OFS_CFG      12'h000
`define SBSC_OFS_STAT     12'h004
`define SBSC_OFS_RDCNT    12'h008
`define SBSC_OFS_WRCNT    12'h00C

`define SBSC_CFG_PIPE     0
`define SBSC_CFG_ILEAVE   1
`define SBSC_CFG_NOPAR    2
`define SBSC_CFG_SLEEP    3
`define SBSC_CFG_W        4
`define SBSC_CFG_RST      4'h3

`define SBSC_ST_ADDR_LSB  0
`define SBSC_ST_ADDR_MSB  1
`define SBSC_ST_ACTIVE    2
`define SBSC_ST_WRITE     3
`define SBSC_ST_SLEEP     4
`define SBSC_ST_DRIVE     5

`define SBSC_BURST_RST    2'h0
`define SBSC_BURST_STEP   2'h1
`define SBSC_CNT_RST      32'h0000_0000
`define SBSC_CNT_STEP     32'h0000_0001

`endif

// ===== rtl/sbsc_pkg.sv
// types shared by the burst memory control modules
package sbsc_pkg;
   typedef enum logic [1:0] {sbsc_idle, sbsc_read, sbsc_write} sbsc_state_t;
   typedef logic [1:0] sbsc_burst_t;
endpackage : sbsc_pkg

// ===== rtl/sbsc_ctr_if.sv
// link between the control decode and the two-bit burst counter
`timescale 1ns/10ps
interface sbsc_ctr_if;
   logic                  load;
   logic                  advance;
   logic                  interleave;
   sbsc_pkg::sbsc_burst_t preset;
   sbsc_pkg::sbsc_burst_t addr_lo;
   modport ctl (output load, output advance, output interleave, output preset, input addr_lo);
   modport ctr (input load, input advance, input interleave, input preset, output addr_lo);
endinterface : sbsc_ctr_if

// ===== rtl/sbsc_burst_ctr.sv
// two-bit burst address counter, linear or interleaved order
`timescale 1ns/10ps
`include "sbsc_defs.svh"
module sbsc_burst_ctr (
   input  wire logic pclk,     // clock
   input  wire logic presetn,  // async reset, low
   sbsc_ctr_if.ctr   cif       // load/advance in, low address out
);
   sbsc_pkg::sbsc_burst_t start_r;
   sbsc_pkg::sbsc_burst_t start_nxt;
   sbsc_pkg::sbsc_burst_t step_r;
   sbsc_pkg::sbsc_burst_t step_nxt;

   always_comb
   begin
      start_nxt = start_r;
      step_nxt  = step_r;
      if (cif.load)
      begin
         start_nxt = cif.preset;
         step_nxt  = `SBSC_BURST_RST;
      end
      else if (cif.advance)
      begin
         // two bits wrap by themselves, so the fifth address is the first again
         step_nxt = sbsc_pkg::sbsc_burst_t'(step_r + `SBSC_BURST_STEP);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_r <= `SBSC_BURST_RST;
         step_r  <= `SBSC_BURST_RST;
      end
      else
      begin
         start_r <= start_nxt;
         step_r  <= step_nxt;
      end
   end

   assign cif.addr_lo = cif.interleave ? (start_r ^ step_r)
                                       : sbsc_pkg::sbsc_burst_t'(start_r + step_r);
endmodule : sbsc_burst_ctr

// ===== rtl/sbsc_top.sv
// control logic of a synchronous burst static memory with an APB register port
// Notes on behaviour
// - low address bits preset the burst counter
// - one active-low write enable per lane
// - byte gate low writes only enabled lanes
// - global write low writes every lane
// - selected when first, third low, second high
// - advance low without strobe steps counter
// - two strobes, processor and cache, load address
// - output enable high turns drivers off
// - sleep high enters standby, low is normal
// - sleep defaults to normal operation
// - flow-through bypasses, pipeline registers read data
// - burst order selects linear or interleaved
// - linear order counts up modulo four
// - interleaved order is start xor step
// - reads drive all byte lanes
// - writes keep every data pin undriven
// - lanes c and d only in wide build
// - parity select high gives 32-bit data
// - first enable high with cache strobe deselects
// - processor strobe when enabled starts read burst
// - no strobe continues or suspends the burst
// - reads with outputs off still advance counter
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "sbsc_defs.svh"
module sbsc_top #(
   parameter int LANES  = `SBSC_MAX_LANES, // 4 wide build, 2 narrow build
   parameter int HI_W   = 16,              // upper address bits
   parameter int LANE_W = `SBSC_LANE_W     // 8 data bits and a parity bit
) (
   input  wire logic                        pclk,              // clock
   input  wire logic                        presetn,           // async reset, low
   input  wire logic [`SBSC_APB_AW-1:0]     paddr,             // apb address
   input  wire logic                        psel,              // apb select
   input  wire logic                        penable,           // apb enable
   input  wire logic                        pwrite,            // apb direction
   input  wire logic [`SBSC_APB_DW-1:0]     pwdata,            // apb write data
   output logic      [`SBSC_APB_DW-1:0]     prdata,            // apb read data
   output logic                             pready,            // apb ready
   output logic                             pslverr,           // apb error
   input  wire logic [HI_W-1:0]             addr_hi,           // upper address
   input  wire logic                        addr_bit0_preset,  // address bit 0
   input  wire logic                        addr_bit1_preset,  // address bit 1
   input  wire logic                        select_first_n,    // chip enable 1, low
   input  wire logic                        select_second,     // chip enable 2, high
   input  wire logic                        select_third_n,    // chip enable 3, low
   input  wire logic                        processor_strobe_n,// processor strobe, low
   input  wire logic                        cache_strobe_n,    // cache strobe, low
   input  wire logic                        counter_advance_n, // burst advance, low
   input  wire logic                        write_all_lanes_n, // global write, low
   input  wire logic                        byte_write_gate_n, // byte write gate, low
   input  wire logic                        lane_a_write_n,    // lane a write, low
   input  wire logic                        lane_b_write_n,    // lane b write, low
   input  wire logic                        lane_c_write_n,    // lane c write, low
   input  wire logic                        lane_d_write_n,    // lane d write, low
   input  wire logic                        output_enable_n,   // output enable, low
   input  wire logic                        sleep_request,     // standby request, high
   input  wire logic [LANES*LANE_W-1:0]     dq_in,             // data pins, input side
   output logic      [LANES*LANE_W-1:0]     dq_out,            // data pins, output side
   output logic      [LANES*LANE_W-1:0]     dq_oe,             // data pins, drive enable
   output logic      [HI_W+1:0]             mem_addr,          // array address
   output logic      [LANES*LANE_W-1:0]     mem_bit_we,        // array bit write enables
   output logic      [LANES*LANE_W-1:0]     mem_wdata,         // array write data
   input  wire logic [LANES*LANE_W-1:0]     mem_rdata          // array read data
);
   localparam int DQ_W = LANES * LANE_W;

   // bit mask covering the chosen lanes; parity bits dropped in 32-bit mode
   function automatic logic [DQ_W-1:0] lane_mask(input logic [LANES-1:0] lanes,
                                                 input logic            no_par);
      logic [DQ_W-1:0] m;
      m = '0;
      for (int l = 0; l < LANES; l++)
      begin
         for (int b = 0; b < LANE_W; b++)
         begin
            m[l*LANE_W+b] = lanes[l] & ~(no_par & (b == `SBSC_PAR_POS));
         end
      end
      return m;
   endfunction : lane_mask

   sbsc_ctr_if cif ();

   logic [`SBSC_CFG_W-1:0]   cfg_r;
   logic [`SBSC_CFG_W-1:0]   cfg_nxt;
   logic [`SBSC_APB_DW-1:0]  prdata_r;
   logic [`SBSC_APB_DW-1:0]  prdata_nxt;
   logic [`SBSC_APB_DW-1:0]  rd_cnt_r;
   logic [`SBSC_APB_DW-1:0]  rd_cnt_nxt;
   logic [`SBSC_APB_DW-1:0]  wr_cnt_r;
   logic [`SBSC_APB_DW-1:0]  wr_cnt_nxt;
   sbsc_pkg::sbsc_state_t    state_r;
   sbsc_pkg::sbsc_state_t    state_nxt;
   logic [HI_W-1:0]          addr_hi_r;
   logic [HI_W-1:0]          addr_hi_nxt;
   logic [LANES-1:0]         we_r;
   logic [LANES-1:0]         we_nxt;
   logic [DQ_W-1:0]          wdata_r;
   logic [DQ_W-1:0]          rdata_r;
   logic                     rd_pipe_r;
   logic                     rd_pipe_nxt;

   logic                     cfg_pipe;
   logic                     cfg_ileave;
   logic                     cfg_nopar;
   logic                     sleep_eff;
   logic                     chip_sel;
   logic                     proc_load;
   logic                     strobe;
   logic [`SBSC_MAX_LANES-1:0] lane_low_all;
   logic [LANES-1:0]         lane_low;
   logic [LANES-1:0]         wr_lanes;
   logic                     is_write;
   logic                     load;
   logic                     advance;
   logic                     drive;
   logic                     acc;
   logic                     hit_cfg;
   logic                     hit_stat;
   logic                     hit_rd;
   logic                     hit_wr;
   logic [`SBSC_APB_DW-1:0]  status;

   assign cfg_pipe   = cfg_r[`SBSC_CFG_PIPE];
   assign cfg_ileave = cfg_r[`SBSC_CFG_ILEAVE];
   assign cfg_nopar  = cfg_r[`SBSC_CFG_NOPAR];
   // the software bit resets to 0, so an idle pin means normal operation
   assign sleep_eff  = sleep_request | cfg_r[`SBSC_CFG_SLEEP];

   // command decode of the pins, all sampled at the next rising edge
   always_comb
   begin
      chip_sel     = ~select_first_n & select_second & ~select_third_n;
      // processor strobe only counts while the first enable is low
      proc_load    = ~processor_strobe_n & ~select_first_n;
      strobe       = ~cache_strobe_n | proc_load;
      lane_low_all = ~{lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};
      // lanes c and d fall away in the narrow build
      lane_low     = lane_low_all[LANES-1:0];
      if (!write_all_lanes_n)
      begin
         wr_lanes = '1;
      end
      else if (!byte_write_gate_n)
      begin
         wr_lanes = lane_low;
      end
      else
      begin
         wr_lanes = '0;
      end
      is_write = |wr_lanes;
   end

   // cycle state, external address and lane enables
   always_comb
   begin
      state_nxt   = sbsc_pkg::sbsc_idle;
      addr_hi_nxt = addr_hi_r;
      we_nxt      = '0;
      load        = 1'b0;
      advance     = 1'b0;
      if (sleep_eff)
      begin
         // standby: nothing is started and the burst position is kept
         state_nxt = sbsc_pkg::sbsc_idle;
      end
      else if (strobe)
      begin
         if (chip_sel)
         begin
            load        = 1'b1;
            addr_hi_nxt = addr_hi;
            if (proc_load)
            begin
               state_nxt = sbsc_pkg::sbsc_read;
            end
            else if (is_write)
            begin
               state_nxt = sbsc_pkg::sbsc_write;
               we_nxt    = wr_lanes;
            end
            else
            begin
               state_nxt = sbsc_pkg::sbsc_read;
            end
         end
         else
         begin
            state_nxt = sbsc_pkg::sbsc_idle;
         end
      end
      else if (state_r != sbsc_pkg::sbsc_idle)
      begin
         // continue on advance low, otherwise repeat the current address
         advance = ~counter_advance_n;
         if (is_write)
         begin
            state_nxt = sbsc_pkg::sbsc_write;
            we_nxt    = wr_lanes;
         end
         else
         begin
            state_nxt = sbsc_pkg::sbsc_read;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r   <= sbsc_pkg::sbsc_idle;
         addr_hi_r <= '0;
         we_r      <= '0;
         wdata_r   <= '0;
      end
      else
      begin
         state_r   <= state_nxt;
         addr_hi_r <= addr_hi_nxt;
         we_r      <= we_nxt;
         wdata_r   <= dq_in;
      end
   end

   assign cif.load       = load;
   assign cif.advance    = advance;
   assign cif.interleave = cfg_ileave;
   assign cif.preset     = {addr_bit1_preset, addr_bit0_preset};

   sbsc_burst_ctr u_ctr (
      .pclk    (pclk),
      .presetn (presetn),
      .cif     (cif)
   );

   // array side
   assign mem_addr   = {addr_hi_r, cif.addr_lo};
   assign mem_wdata  = wdata_r;
   assign mem_bit_we = (state_r == sbsc_pkg::sbsc_write) ? lane_mask(we_r, cfg_nopar) : '0;

   // output data register, used only in pipeline mode
   always_comb
   begin
      rd_pipe_nxt = (state_r == sbsc_pkg::sbsc_read);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_pipe_r <= 1'b0;
         rdata_r   <= '0;
      end
      else
      begin
         rd_pipe_r <= rd_pipe_nxt;
         rdata_r   <= mem_rdata;
      end
   end

   // pipeline trades a cycle of latency for a registered output
   assign dq_out = cfg_pipe ? rdata_r : mem_rdata;
   assign drive  = (cfg_pipe ? rd_pipe_r : (state_r == sbsc_pkg::sbsc_read))
                   & (state_r != sbsc_pkg::sbsc_write);
   // output enable and sleep gate the drivers without waiting for a clock
   assign dq_oe  = (drive & ~output_enable_n & ~sleep_eff)
                   ? lane_mask('1, cfg_nopar) : '0;

   // register port: zero wait states
   assign acc      = psel & penable;
   assign hit_cfg  = (paddr == `SBSC_OFS_CFG);
   assign hit_stat = (paddr == `SBSC_OFS_STAT);
   assign hit_rd   = (paddr == `SBSC_OFS_RDCNT);
   assign hit_wr   = (paddr == `SBSC_OFS_WRCNT);
   assign pready   = 1'b1;
   // status is read only; writes there and unmapped addresses are refused
   assign pslverr  = acc & ~(hit_cfg | hit_rd | hit_wr | (hit_stat & ~pwrite));
   assign prdata   = prdata_r;

   always_comb
   begin
      status = '0;
      status[`SBSC_ST_ADDR_MSB:`SBSC_ST_ADDR_LSB] = cif.addr_lo;
      status[`SBSC_ST_ACTIVE] = (state_r != sbsc_pkg::sbsc_idle);
      status[`SBSC_ST_WRITE]  = (state_r == sbsc_pkg::sbsc_write);
      status[`SBSC_ST_SLEEP]  = sleep_eff;
      status[`SBSC_ST_DRIVE]  = |dq_oe;
   end

   always_comb
   begin
      cfg_nxt    = cfg_r;
      prdata_nxt = prdata_r;
      rd_cnt_nxt = rd_cnt_r;
      wr_cnt_nxt = wr_cnt_r;
      if (acc & pwrite & hit_cfg)
      begin
         cfg_nxt = pwdata[`SBSC_CFG_W-1:0];
      end
      if (acc & pwrite & hit_rd)
      begin
         rd_cnt_nxt = `SBSC_CNT_RST;
      end
      if (acc & pwrite & hit_wr)
      begin
         wr_cnt_nxt = `SBSC_CNT_RST;
      end
      // a cycle landing on the clearing write still counts
      if (state_r == sbsc_pkg::sbsc_read)
      begin
         rd_cnt_nxt = rd_cnt_nxt + `SBSC_CNT_STEP;
      end
      if (state_r == sbsc_pkg::sbsc_write)
      begin
         wr_cnt_nxt = wr_cnt_nxt + `SBSC_CNT_STEP;
      end
      if (psel & ~penable & ~pwrite)
      begin
         if (hit_cfg)
         begin
            prdata_nxt = {{(`SBSC_APB_DW-`SBSC_CFG_W){1'b0}}, cfg_r};
         end
         else if (hit_stat)
         begin
            prdata_nxt = status;
         end
         else if (hit_rd)
         begin
            prdata_nxt = rd_cnt_r;
         end
         else if (hit_wr)
         begin
            prdata_nxt = wr_cnt_r;
         end
         else
         begin
            prdata_nxt = '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_r    <= `SBSC_CFG_RST;
         prdata_r <= `SBSC_CNT_RST;
         rd_cnt_r <= `SBSC_CNT_RST;
         wr_cnt_r <= `SBSC_CNT_RST;
      end
      else
      begin
         cfg_r    <= cfg_nxt;
         prdata_r <= prdata_nxt;
         rd_cnt_r <= rd_cnt_nxt;
         wr_cnt_r <= wr_cnt_nxt;
      end
   end
endmodule : sbsc_top

// ===== test/sbsc_properties.sv
// concurrent checks on the ports of the burst memory control block
`timescale 1ns/10ps
module sbsc_properties #(
   parameter int LANES  = 4,  // lane count
   parameter int HI_W   = 16, // upper address bits
   parameter int LANE_W = 9   // bits per lane
) (
   input wire logic                    pclk,               // clock
   input wire logic                    presetn,            // reset, low
   input wire logic                    addr_bit0_preset,   // preset bit 0
   input wire logic                    addr_bit1_preset,   // preset bit 1
   input wire logic                    select_first_n,     // enable 1
   input wire logic                    select_second,      // enable 2
   input wire logic                    select_third_n,     // enable 3
   input wire logic                    processor_strobe_n, // processor strobe
   input wire logic                    cache_strobe_n,     // cache strobe
   input wire logic                    counter_advance_n,  // advance
   input wire logic                    write_all_lanes_n,  // global write
   input wire logic                    output_enable_n,    // output enable
   input wire logic                    sleep_request,      // standby
   input wire logic [LANES*LANE_W-1:0] dq_oe,              // drive enables
   input wire logic [HI_W+1:0]         mem_addr,           // array address
   input wire logic [LANES*LANE_W-1:0] mem_bit_we          // write enables
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic sel;
   logic ld;
   logic quiet;
   assign sel   = ~select_first_n & select_second & ~select_third_n;
   assign ld    = (~cache_strobe_n | ~processor_strobe_n & ~select_first_n) & sel & ~sleep_request;
   assign quiet = cache_strobe_n & processor_strobe_n & ~sleep_request;
   a_oe_off: assert property (output_enable_n |-> dq_oe == '0)
      else $error("drivers on with output enable high");
   a_write_hiz: assert property (|mem_bit_we |-> dq_oe == '0)
      else $error("drivers on during write");
   a_global_write: assert property (ld & processor_strobe_n & ~write_all_lanes_n |=> &mem_bit_we[7:0])
      else $error("global write missed a lane");
   a_proc_read: assert property (ld & ~processor_strobe_n |=> mem_bit_we == '0)
      else $error("processor strobe wrote");
   a_preset_load: assert property (ld |=> mem_addr[1:0] == {$past(addr_bit1_preset), $past(addr_bit0_preset)})
      else $error("counter not preset");
   a_suspend_hold: assert property (ld ##1 (quiet & counter_advance_n) |=> $stable(mem_addr))
      else $error("address moved while suspended");
   a_advance_step: assert property (ld ##1 (quiet & ~counter_advance_n) |=> $changed(mem_addr[1:0]))
      else $error("counter did not advance");
   a_desel_idle: assert property (select_first_n & ~cache_strobe_n |=> mem_bit_we == '0)
      else $error("write on deselect");
   a_sleep_idle: assert property (sleep_request |=> mem_bit_we == '0)
      else $error("write while asleep");
endmodule : sbsc_properties

// ===== test/sbsc_array_model.sv
// behavioural array behind the control block, four words deep
`timescale 1ns/10ps
module sbsc_array_model (
   input  wire logic        pclk,       // clock
   input  wire logic [17:0] mem_addr,   // word address
   input  wire logic [35:0] mem_bit_we, // bit write enables
   input  wire logic [35:0] mem_wdata,  // write data
   output logic      [35:0] mem_rdata   // read data, no latency
);
   logic [35:0] arr_r [4];
   // only the low bits decode: one burst is all the bench needs
   initial
      for (int w = 0; w < 4; w++)
         arr_r[w] = {4{9'h0A0 + 9'(w)}};
   assign mem_rdata = arr_r[mem_addr[1:0]];
   always @(posedge pclk)
      for (int b = 0; b < 36; b++)
         if (mem_bit_we[b])
            arr_r[mem_addr[1:0]][b] <= mem_wdata[b];
endmodule : sbsc_array_model

// ===== test/test_sync_burst_sram_control.sv
// self-checking bench for the burst memory control block
`timescale 1ns/10ps
module test_sync_burst_sram_control;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] addr_hi;
   logic        addr_bit0_preset, addr_bit1_preset, select_first_n, select_second;
   logic        select_third_n, processor_strobe_n, cache_strobe_n, counter_advance_n;
   logic        write_all_lanes_n, byte_write_gate_n, output_enable_n, sleep_request;
   logic        lane_a_write_n, lane_b_write_n, lane_c_write_n, lane_d_write_n;
   logic [35:0] dq_in, dq_out, dq_oe, mem_bit_we, mem_wdata, mem_rdata;
   logic [17:0] mem_addr;
   logic [2:0]  ce_q;
   logic [1:0]  s_q;
   logic        oe_q, slp_q;
   logic [35:0] d_q;
   int          error_cnt, n_compared;
   sbsc_top i_sbsc_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .addr_hi, .addr_bit0_preset, .addr_bit1_preset, .select_first_n,
      .select_second, .select_third_n, .processor_strobe_n, .cache_strobe_n,
      .counter_advance_n, .write_all_lanes_n, .byte_write_gate_n, .lane_a_write_n,
      .lane_b_write_n, .lane_c_write_n, .lane_d_write_n, .output_enable_n, .sleep_request,
      .dq_in, .dq_out, .dq_oe, .mem_addr, .mem_bit_we, .mem_wdata, .mem_rdata);
   sbsc_array_model i_sbsc_array_model (.pclk, .mem_addr, .mem_bit_we, .mem_wdata, .mem_rdata);
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cfg(input logic [31:0] v);
      logic [31:0] q;
      logic        e;
      apb(1'b1, 12'h000, v, q, e);
   endtask : cfg
   // pins take effect at the next edge, output enable and sleep at once on dq_oe; checks after return see the previous edge
   task automatic pins(input logic cs_n, input logic ps_n, input logic step_n,
                       input logic wall_n, input logic gate_n, input logic [3:0] ln_n);
      @(posedge pclk);
      cache_strobe_n     <= cs_n;
      processor_strobe_n <= ps_n;
      counter_advance_n  <= step_n;
      write_all_lanes_n  <= wall_n;
      byte_write_gate_n  <= gate_n;
      dq_in              <= d_q;
      {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} <= ln_n;
      {select_first_n, select_second, select_third_n} <= ce_q;
      {addr_bit1_preset, addr_bit0_preset} <= s_q;
      output_enable_n <= oe_q;
      sleep_request   <= slp_q;
      #1;
   endtask : pins
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      apb(1'b0, 12'h000, 32'h0, q, e);
      chk(q, 36'h3);
      apb(1'b0, 12'h004, 32'h0, q, e);
      chk(q, 36'h0);
      apb(1'b0, 12'h010, 32'h0, q, e);
      chk({q, 3'h0, e}, 36'h1);
      // status is read only: refused, and read data keeps standing
      apb(1'b1, 12'h004, 32'h3F, q, e);
      chk({q, 3'h0, e}, 36'h1);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_order;
      logic [1:0] x;
      for (int o = 0; o < 2; o++)
      begin
         cfg({30'h0, o[0], 1'b1});
         ce_q = 3'b110;
         pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF);
         ce_q = 3'b010;
         s_q  = 2'h1;
         pins(o[0], ~o[0], 1'b1, 1'b1, 1'b1, 4'hF);
         for (int n = 0; n < 5; n++)
         begin
            pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF);
            x = o[0] ? (s_q ^ n[1:0]) : (s_q + n[1:0]);
            chk(mem_addr[1:0], x);
         end
         chk(mem_addr[17:2], addr_hi);
      end
      $display("t_order done");
   endtask : t_order
   task automatic t_read;
      for (int f = 0; f < 2; f++)
      begin
         cfg({31'h0, f[0]});
         ce_q = 3'b110;
         pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
         ce_q = 3'b010;
         s_q  = 2'h2;
         pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
         pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
         pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
         chk(dq_oe, f[0] ? 36'h0 : {36{1'b1}});
         pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
         chk(dq_oe, {36{1'b1}});
         chk(dq_out, {4{9'h0A2}});
         oe_q = 1'b1;
         pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
         chk(dq_oe, 36'h0);
         pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
         chk(mem_addr[1:0], 2'h3);
         oe_q = 1'b0;
      end
      $display("t_read done");
   endtask : t_read
   task automatic t_write;
      // {cache strobe, global, gate, lanes d..a, lanes written}
      logic [10:0] rw [6] = '{11'h5FF, 11'h6A5, 11'h700, 11'h6F0, 11'h1F0, 11'h678};
      logic [35:0] x;
      for (int r = 0; r < 7; r++)
      begin
         // fresh data each cycle, so a stale capture shows up
         d_q = {4{9'h100 + 9'(r)}};
         if (r < 6)
            pins(~rw[r][10], rw[r][10], 1'b1, rw[r][9], rw[r][8], rw[r][7:4]);
         else
            pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF);
         if (r > 0)
         begin
            for (int l = 0; l < 4; l++)
               x[9*l +: 9] = {9{rw[r-1][l]}};
            chk(mem_bit_we, x);
            if (|x)
            begin
               chk(dq_oe, 36'h0);
               chk(mem_wdata, {4{9'h100 + 9'(r - 1)}});
            end
         end
      end
      cfg(32'h7);
      pins(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF);
      pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF);
      chk(mem_bit_we, {4{9'h0FF}});
      cfg(32'h3);
      $display("t_write done");
   endtask : t_write
   task automatic t_select;
      for (int i = 0; i < 9; i++)
      begin
         ce_q = i[2:0];
         pins(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF);
         if (i > 0)
            chk(mem_bit_we, (i == 3) ? {36{1'b1}} : 36'h0);
      end
      ce_q  = 3'b010;
      slp_q = 1'b1;
      pins(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF);
      pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF);
      chk(mem_bit_we, 36'h0);
      chk(dq_oe, 36'h0);
      slp_q = 1'b0;
      $display("t_select done");
   endtask : t_select
   initial
   begin
      #40000;
      error_cnt++;
      close_out();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, addr_bit0_preset, addr_bit1_preset} = 49'h0;
      {processor_strobe_n, cache_strobe_n, counter_advance_n, write_all_lanes_n} = 4'hF;
      {byte_write_gate_n, lane_a_write_n, lane_b_write_n, lane_c_write_n} = 4'hF;
      lane_d_write_n = 1'b1;
      {select_first_n, select_second, select_third_n, ce_q} = 6'h12;
      {output_enable_n, sleep_request, oe_q, slp_q, s_q} = 6'h0;
      addr_hi    = 16'hA5C3;
      {dq_in, d_q} = {2{36'h9_5A3C_C3A5}};
      error_cnt  = 0;
      n_compared = 0;
      presetn    = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_order();
      t_read();
      t_write();
      t_select();
      close_out();
   end
endmodule : test_sync_burst_sram_control
bind sbsc_top sbsc_properties #(.LANES(LANES), .HI_W(HI_W), .LANE_W(LANE_W)) i_sbsc_properties (
   .pclk, .presetn, .addr_bit0_preset, .addr_bit1_preset, .select_first_n, .select_second,
   .select_third_n, .processor_strobe_n, .cache_strobe_n, .counter_advance_n,
   .write_all_lanes_n, .output_enable_n, .sleep_request, .dq_oe, .mem_addr, .mem_bit_we);
